// File: dv/drum_clock_model.sv
// Purpose: drum unit clock input, counts received pulses
// Assumes: edge-triggered input, no reply to the sender
// Notes: count is never cleared; users take differences
`timescale 1ns/10ps
module drum_clock_model (
	// Clock input jack
	input wire clk_in,
	// Observation
	output integer pulses
);
	initial pulses = 0;
	always @(posedge clk_in) pulses <= pulses + 1;
endmodule

// File: dv/loop_clock_ctrl_asserts.sv
// Purpose: port-level temporal checks of loop_clock_ctrl
// Assumes: shortened message and lamp counts handed on by the bind
// Notes: helper counters measure how long the clock pulse, the lamp flash and the clock-off message stay up
`timescale 1ns/10ps
module loop_clock_ctrl_asserts #(
	parameter CLOFF_CYC = 20,
	parameter LAMP_CYC = 10
) (
	// Clock and reset
	input wire CLK,
	input wire RESET_N,
	// Panel and memory outputs
	input wire [1:0] DISP_MODE,
	input wire [6:0] DISP_PPB,
	input wire [4:0] DISP_BPL,
	input wire CLK_LAMP,
	input wire HOLD_ACTIVE,
	input wire CLOCK_OUT,
	input wire MEM_WRITE_EN,
	input wire [7:0] FEEDBACK_GAIN,
	// Bus handshakes
	input wire AWVALID,
	input wire AWREADY,
	input wire WVALID,
	input wire WREADY,
	input wire BVALID,
	input wire ARVALID,
	input wire ARREADY,
	input wire RVALID
);
	localparam [95:0] PPB_SEQ = 96'h01_02_03_04_06_08_0c_10_18_20_30_40;
	localparam [95:0] BPL_SEQ = 96'h01_02_04_08_10;
	reg [31:0] hi_r, lamp_r, msg_r;

	// Last entry falls through to the first, so the wrap is checked too
	function automatic [7:0] seq_next(input [95:0] s, input integer n, input [7:0] v);
		seq_next = s[8*(n-1) +: 8];
		for (int i = 1; i < n; i++)
			if (s[8*i +: 8] == v)
				seq_next = s[8*(i-1) +: 8];
	endfunction

	// ----------------------------------------
	// Length counters
	// ----------------------------------------
	always @(posedge CLK) begin
		if (!RESET_N) begin
			hi_r <= 32'h0;
			lamp_r <= 32'h0;
			msg_r <= 32'h0;
		end else begin
			hi_r <= CLOCK_OUT ? hi_r + 32'h1 : 32'h0;
			lamp_r <= CLK_LAMP ? lamp_r + 32'h1 : 32'h0;
			msg_r <= (DISP_MODE == 2'h1) ? msg_r + 32'h1 : 32'h0;
		end
	end

	default clocking dc @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	property p_rst;
		$rose(RESET_N) |-> DISP_PPB == 7'h01 && DISP_BPL == 5'h01 && !HOLD_ACTIVE;
	endproperty
	a_rst: assert property (p_rst) else $error("program values not 01 01 after reset");
	property p_ppb;
		$changed(DISP_PPB) && $past(RESET_N) |-> $past(DISP_MODE) != 2'h0 &&
			{1'b0, DISP_PPB} == seq_next(PPB_SEQ, 12, {1'b0, $past(DISP_PPB)});
	endproperty
	a_ppb: assert property (p_ppb) else $error("pulses per beat stepped wrongly");
	property p_bpl;
		$changed(DISP_BPL) && $past(RESET_N) |-> $past(DISP_MODE) != 2'h0 &&
			{3'h0, DISP_BPL} == seq_next(BPL_SEQ, 5, {3'h0, $past(DISP_BPL)});
	endproperty
	a_bpl: assert property (p_bpl) else $error("beats per loop stepped wrongly");
	property p_cloff;
		$fell(DISP_MODE == 2'h1) |-> DISP_MODE == 2'h2 && msg_r == CLOFF_CYC;
	endproperty
	a_cloff: assert property (p_cloff) else $error("clock-off message misplaced");
	property p_pulse;
		$fell(CLOCK_OUT) |-> hi_r == 32'd50;
	endproperty
	a_pulse: assert property (p_pulse) else $error("clock pulse width wrong");
	property p_lamp;
		$rose(CLK_LAMP) |-> CLOCK_OUT;
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp flash without a pulse");
	property p_lamp_len;
		$fell(CLK_LAMP) |-> lamp_r == LAMP_CYC;
	endproperty
	a_lamp_len: assert property (p_lamp_len) else $error("lamp flash length wrong");
	property p_hold;
		HOLD_ACTIVE |-> !MEM_WRITE_EN && FEEDBACK_GAIN == 8'hff;
	endproperty
	a_hold: assert property (p_hold) else $error("frozen memory still written");
	property p_wr;
		AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !BVALID ##1 BVALID;
	endproperty
	a_wr: assert property (p_wr) else $error("write response timing wrong");
	property p_rd;
		ARVALID && ARREADY |=> RVALID && !ARREADY;
	endproperty
	a_rd: assert property (p_rd) else $error("read data timing wrong");
endmodule

bind loop_clock_ctrl loop_clock_ctrl_asserts #(.CLOFF_CYC(CLOFF_CYC), .LAMP_CYC(LAMP_CYC)) chk_i (
	.CLK(CLK), .RESET_N(RESET_N), .DISP_MODE(DISP_MODE), .DISP_PPB(DISP_PPB),
	.DISP_BPL(DISP_BPL), .CLK_LAMP(CLK_LAMP), .HOLD_ACTIVE(HOLD_ACTIVE), .CLOCK_OUT(CLOCK_OUT),
	.MEM_WRITE_EN(MEM_WRITE_EN), .FEEDBACK_GAIN(FEEDBACK_GAIN), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
	.ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID));

// File: dv/tb_loop_clock_ctrl.sv
// Purpose: self-checking bench for the loop clock and repeat control
// Assumes: shortened timing parameters; integer model of the sequences
// Notes: beats measured between lamp rises, pulses counted by the drum model
`timescale 1ns/10ps
module tb_loop_clock_ctrl;
	reg CLK = 1'b0;
	reg RESET_N = 1'b0;
	reg [5:0] btn = 6'h0;
	reg [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hf;
	reg [31:0] WDATA = 32'h0;
	reg AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	wire [1:0] DISP_MODE, BRESP, RRESP;
	wire [6:0] DISP_PPB;
	wire [4:0] DISP_BPL;
	wire [7:0] FEEDBACK_GAIN;
	wire [31:0] RDATA;
	wire LONG_RANGE, CLK_LAMP, HOLD_ACTIVE, CLOCK_OUT, MEM_WRITE_EN;
	wire AWREADY, WREADY, BVALID, ARREADY, RVALID;
	integer errors = 0, compares = 0, seed = 32'h7c104bfd;
	integer t, k, cy, np, dp, len = 800, pi = 0, bi = 0;
	integer ppb_tab [0:11] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64};
	integer bpl_tab [0:4] = '{1, 2, 4, 8, 16};
	reg [7:0] fb;
	reg hb;

	loop_clock_ctrl #(.PAIR_CYC(8), .CLOFF_CYC(20), .PROG_CYC(40), .LAMP_CYC(10)) uut (
		.CLK, .RESET_N, .RANGE_CLOCK_BTN_L(btn[0]), .RANGE_CLOCK_BTN_R(btn[1]),
		.DIVIDE_BTN(btn[2]), .MULTIPLY_BTN(btn[3]), .INFINITE_REPEAT_BTN(btn[4]),
		.REPEAT_FOOTSWITCH(btn[5]), .DISP_MODE, .DISP_PPB, .DISP_BPL, .LONG_RANGE, .CLK_LAMP,
		.HOLD_ACTIVE, .CLOCK_OUT, .MEM_WRITE_EN, .FEEDBACK_GAIN, .AWADDR, .AWVALID, .AWREADY,
		.WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
		.ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	drum_clock_model drum (.clk_in(CLOCK_OUT), .pulses(dp));

	initial forever #50 CLK = ~CLK;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		compares = compares + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task conclude;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task tmo(input ok);
		if (!ok) begin
			chk("timeout", 0, 1);
			conclude;
		end
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge CLK);
		#1;
	endtask
	task wr(input [3:0] a, input [31:0] d, input [1:0] er);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge CLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
			if (BVALID)
				break;
		end
		BREADY <= 1'b0;
		tmo(t < 50);
		chk("bresp", BRESP, er);
	endtask
	task rd(input [3:0] a, input [31:0] ed, input [1:0] er);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge CLK);
			if (ARREADY)
				ARVALID <= 1'b0;
			if (RVALID)
				break;
		end
		RREADY <= 1'b0;
		tmo(t < 50);
		chk("rdata", RDATA, ed);
		chk("rresp", RRESP, er);
	endtask
	// Released inside the pairing window; the wait after release lets a single press be seen as single
	task press(input [5:0] m);
		@(posedge CLK);
		btn <= m;
		repeat (6) @(posedge CLK);
		btn <= 6'h0;
		cyc(14);
	endtask
	task wmode(input [1:0] m);
		for (t = 0; t < 300 && DISP_MODE !== m; t++)
			cyc(1);
		tmo(t < 300);
	endtask
	// Waits for the next lamp rise; hb keeps the repeat state just before it
	task lamp;
		reg lp;
		integer d0;
		d0 = dp;
		cy = 0;
		for (t = 0; t < 9000; t++) begin
			lp = CLK_LAMP;
			hb = HOLD_ACTIVE;
			@(posedge CLK);
			#1;
			cy++;
			if (CLK_LAMP && !lp)
				break;
		end
		np = dp - d0;
		tmo(t < 9000);
	endtask
	task rsync(input [5:0] m, input e);
		lamp;
		press(m);
		chk("hold early", HOLD_ACTIVE, !e);
		lamp;
		chk("hold before beat", hb, !e);
		cyc(2);
		chk("hold", {HOLD_ACTIVE, MEM_WRITE_EN, FEEDBACK_GAIN}, {e, !e, e ? 8'hff : fb});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		cyc(2);
		chk("ppb", DISP_PPB, 1);
		chk("bpl", DISP_BPL, 1);
		chk("idle", {DISP_MODE, LONG_RANGE, HOLD_ACTIVE, MEM_WRITE_EN, FEEDBACK_GAIN}, 13'h100);
		rd(4'h4, 32'h4e2000, 2'h0);
		rd(4'h8, 32'h8, 2'h0);
		rd(4'h2, 32'h0, 2'h2);
		wr(4'h2, 32'h55, 2'h2);
		wr(4'h8, 32'hffffffff, 2'h0);
		rd(4'h8, 32'h8, 2'h0);
		wr(4'h4, len, 2'h0);
		$display("test registers done");
		press(6'h3);
		chk("long", LONG_RANGE, 1);
		rd(4'h8, 32'h9, 2'h0);
		press(6'h3);
		chk("long", LONG_RANGE, 0);
		$display("test range done");
		press(6'h8);
		chk("ppb idle", DISP_PPB, 1);
		press(6'h1);
		chk("mode", DISP_MODE, 1);
		wmode(2'h2);
		chk("shown", {DISP_PPB, DISP_BPL}, {7'h01, 5'h01});
		for (k = 0; k < 13; k++) begin
			press(6'h8);
			pi = (pi + 1) % 12;
			chk("ppb", DISP_PPB, ppb_tab[pi]);
		end
		for (k = 0; k < 6; k++) begin
			press(6'h4);
			bi = (bi + 1) % 5;
			chk("bpl", DISP_BPL, bpl_tab[bi]);
		end
		press(6'h3);
		chk("mode run", {DISP_MODE, LONG_RANGE}, 3'h0);
		rd(4'h8, 32'ha, 2'h0);
		rd(4'hc, ppb_tab[pi] + (bpl_tab[bi] << 14), 2'h0);
		$display("test program done");
		for (k = 0; k < 3; k++) begin
			lamp;
			lamp;
			lamp;
			chk("beat", cy, len * (1 + LONG_RANGE) / bpl_tab[bi]);
			chk("pulses", np, ppb_tab[pi]);
			len = 400 + 4 * ($random(seed) & 255);
			wr(4'h4, len, 2'h0);
			if (k == 1)
				press(6'h3);
		end
		chk("long", LONG_RANGE, 1);
		$display("test clock done");
		k = $random(seed);
		fb = k[7:0];
		wr(4'h0, {24'h0, fb}, 2'h0);
		cyc(2);
		chk("gain", FEEDBACK_GAIN, fb);
		rsync(6'h10, 1'b1);
		rsync(6'h20, 1'b0);
		wr(4'h0, 32'h0, 2'h0);
		cyc(2);
		chk("gain off", FEEDBACK_GAIN, 0);
		$display("test repeat done");
		lamp;
		cyc(60);
		press(6'h2);
		wmode(2'h0);
		rd(4'h8, 32'h9, 2'h0);
		press(6'h20);
		chk("hold", HOLD_ACTIVE, 1);
		press(6'h10);
		chk("hold", HOLD_ACTIVE, 0);
		$display("test clock off done");
		conclude;
	end
endmodule

// File: verilog/button_sync.v
// Purpose: two-stage synchroniser with rising-edge pulse for a panel input
// Assumes: input is asynchronous to CLK
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module button_sync (
	// Clock and reset
	input wire CLK,
	input wire RESET_N,
	// Pin side
	input wire pin,
	// Synchronised outputs
	output reg level,
	output reg rise
);
	reg meta_r;
	reg level_d_r;

	// Edge taken from the settled stage only, never from the metastable one
	always @(posedge CLK) begin
		if (!RESET_N) begin
			meta_r <= 1'b0;
			level <= 1'b0;
			level_d_r <= 1'b0;
			rise <= 1'b0;
		end else begin
			meta_r <= pin;
			level <= meta_r;
			level_d_r <= level;
			rise <= level & ~level_d_r;
		end
	end
endmodule

// File: verilog/loop_clock_consts.vh
// Purpose: shared constants of the loop clock and repeat control block
// Assumes: 10 MHz system clock, AXI4-Lite register access
// Notes: times are kept in their own unit; cycle counts derive from them
`ifndef LOOP_CLOCK_CONSTS_VH
`define LOOP_CLOCK_CONSTS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_HZ 10000000
`define PAIR_WINDOW_MS 20
`define CLOFF_SHOW_MS 2000
`define PROG_SHOW_MS 4000
`define LAMP_ON_MS 50
`define CLK_PULSE_US 5
`define MS_TO_CYC(ms) (((ms) * (`CLK_HZ / 1000)))
`define US_TO_CYC(us) (((us) * (`CLK_HZ / 1000000)))

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_LOOP_LEN 4'h4
`define REG_STATUS 4'h8
`define REG_PROG 4'hc

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTRL_FB_LSB 0
`define CTRL_FB_MSB 7
`define FB_FULL 8'hff
`define FB_RESET 8'h00
`define LOOP_LEN_W 24
`define LOOP_LEN_RESET 24'h4e2000
`define PPB_IDX_RESET 4'h0
`define BPL_IDX_RESET 3'h0
`define PPB_IDX_LAST 4'hb
`define BPL_IDX_LAST 3'h4
`define DISP_DELAY 2'h0
`define DISP_CLOFF 2'h1
`define DISP_PROG 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/loop_clock_ctrl.v
// Purpose: panel control of delay range, loop clock and infinite repeat
// Assumes: panel pins asynchronous; delay memory datapath is outside
// Notes: software supplies the 1X loop length and the feedback level
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "loop_clock_consts.vh"
module loop_clock_ctrl #(
	parameter PAIR_CYC = `MS_TO_CYC(`PAIR_WINDOW_MS),
	parameter CLOFF_CYC = `MS_TO_CYC(`CLOFF_SHOW_MS),
	parameter PROG_CYC = `MS_TO_CYC(`PROG_SHOW_MS),
	parameter LAMP_CYC = `MS_TO_CYC(`LAMP_ON_MS)
) (
	// Clock and reset
	input wire CLK,
	input wire RESET_N,
	// Front panel and footswitch pins
	input wire RANGE_CLOCK_BTN_L,
	input wire RANGE_CLOCK_BTN_R,
	input wire DIVIDE_BTN,
	input wire MULTIPLY_BTN,
	input wire INFINITE_REPEAT_BTN,
	input wire REPEAT_FOOTSWITCH,
	// Display and lamps
	output reg [1:0] DISP_MODE,
	output reg [6:0] DISP_PPB,
	output reg [4:0] DISP_BPL,
	output reg LONG_RANGE,
	output reg CLK_LAMP,
	output reg HOLD_ACTIVE,
	// Clock output jack
	output reg CLOCK_OUT,
	// Delay memory control
	output reg MEM_WRITE_EN,
	output reg [7:0] FEEDBACK_GAIN,
	// AXI4-Lite write address
	input wire [3:0] AWADDR,
	input wire AWVALID,
	output reg AWREADY,
	// AXI4-Lite write data
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output reg WREADY,
	// AXI4-Lite write response
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	// AXI4-Lite read
	input wire [3:0] ARADDR,
	input wire ARVALID,
	output reg ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY
);
	localparam CLK_PULSE_CYC = `US_TO_CYC(`CLK_PULSE_US);
	localparam S_NORM = 3'b001;
	localparam S_CLOFF = 3'b010;
	localparam S_PROG = 3'b100;

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	function [6:0] ppb_value;
		input [3:0] idx;
		begin
			case (idx)
				4'h0: ppb_value = 7'h01;
				4'h1: ppb_value = 7'h02;
				4'h2: ppb_value = 7'h03;
				4'h3: ppb_value = 7'h04;
				4'h4: ppb_value = 7'h06;
				4'h5: ppb_value = 7'h08;
				4'h6: ppb_value = 7'h0c;
				4'h7: ppb_value = 7'h10;
				4'h8: ppb_value = 7'h18;
				4'h9: ppb_value = 7'h20;
				4'ha: ppb_value = 7'h30;
				default: ppb_value = 7'h40;
			endcase
		end
	endfunction

	function [4:0] bpl_value;
		input [2:0] idx;
		begin
			bpl_value = 5'h01 << idx;
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire lvl_l, lvl_r, rise_l, rise_r, rise_div, rise_mul, rise_rpt, rise_fsw;

	button_sync u_sync_l (.CLK(CLK), .RESET_N(RESET_N), .pin(RANGE_CLOCK_BTN_L),
		.level(lvl_l), .rise(rise_l));
	button_sync u_sync_r (.CLK(CLK), .RESET_N(RESET_N), .pin(RANGE_CLOCK_BTN_R),
		.level(lvl_r), .rise(rise_r));
	button_sync u_sync_div (.CLK(CLK), .RESET_N(RESET_N), .pin(DIVIDE_BTN),
		.level(), .rise(rise_div));
	button_sync u_sync_mul (.CLK(CLK), .RESET_N(RESET_N), .pin(MULTIPLY_BTN),
		.level(), .rise(rise_mul));
	button_sync u_sync_rpt (.CLK(CLK), .RESET_N(RESET_N), .pin(INFINITE_REPEAT_BTN),
		.level(), .rise(rise_rpt));
	button_sync u_sync_fsw (.CLK(CLK), .RESET_N(RESET_N), .pin(REPEAT_FOOTSWITCH),
		.level(), .rise(rise_fsw));

	// ----------------------------------------
	// Pair detection
	// ----------------------------------------
	// A hand never lands both buttons in one cycle; wait a short window
	reg pair_pend_r;
	reg [31:0] pair_cnt_r;
	reg both_evt_r, single_evt_r;

	always @(posedge CLK) begin
		if (!RESET_N) begin
			pair_pend_r <= 1'b0;
			pair_cnt_r <= 32'h00000000;
			both_evt_r <= 1'b0;
			single_evt_r <= 1'b0;
		end else begin
			both_evt_r <= 1'b0;
			single_evt_r <= 1'b0;
			if (!pair_pend_r) begin
				if (rise_l | rise_r) begin
					pair_pend_r <= 1'b1;
					pair_cnt_r <= 32'h00000000;
				end
			end else if (lvl_l & lvl_r) begin
				pair_pend_r <= 1'b0;
				both_evt_r <= 1'b1;
			end else if (pair_cnt_r >= PAIR_CYC - 1) begin
				pair_pend_r <= 1'b0;
				single_evt_r <= 1'b1;
			end else begin
				pair_cnt_r <= pair_cnt_r + 32'h00000001;
			end
		end
	end

	// ----------------------------------------
	// Panel state machine
	// ----------------------------------------
	reg [2:0] state_r;
	reg [31:0] disp_cnt_r;
	reg clock_on_r, long_range_r;
	reg [3:0] ppb_idx_r;
	reg [2:0] bpl_idx_r;

	always @(posedge CLK) begin
		if (!RESET_N) begin
			state_r <= S_NORM;
			disp_cnt_r <= 32'h00000000;
			clock_on_r <= 1'b0;
			long_range_r <= 1'b0;
			ppb_idx_r <= `PPB_IDX_RESET;
			bpl_idx_r <= `BPL_IDX_RESET;
		end else begin
			disp_cnt_r <= disp_cnt_r + 32'h00000001;
			case (state_r)
				S_NORM: begin
					if (both_evt_r) begin
						long_range_r <= ~long_range_r;
					end else if (single_evt_r) begin
						clock_on_r <= 1'b0;
						state_r <= S_CLOFF;
						disp_cnt_r <= 32'h00000000;
					end
				end
				S_CLOFF: begin
					if (both_evt_r) begin
						long_range_r <= ~long_range_r;
						state_r <= S_NORM;
					end else if (disp_cnt_r >= CLOFF_CYC - 1) begin
						state_r <= S_PROG;
						disp_cnt_r <= 32'h00000000;
					end
				end
				S_PROG: begin
					if (both_evt_r) begin
						clock_on_r <= 1'b1;
						state_r <= S_NORM;
					end else if (rise_div) begin
						disp_cnt_r <= 32'h00000000;
						if (bpl_idx_r == `BPL_IDX_LAST)
							bpl_idx_r <= `BPL_IDX_RESET;
						else
							bpl_idx_r <= bpl_idx_r + 3'h1;
					end else if (rise_mul) begin
						disp_cnt_r <= 32'h00000000;
						if (ppb_idx_r == `PPB_IDX_LAST)
							ppb_idx_r <= `PPB_IDX_RESET;
						else
							ppb_idx_r <= ppb_idx_r + 4'h1;
					end else if (disp_cnt_r >= PROG_CYC - 1) begin
						state_r <= S_NORM;
					end
				end
				default: state_r <= S_NORM;
			endcase
		end
	end

	// ----------------------------------------
	// Loop clock generation
	// ----------------------------------------
	reg [23:0] loop_len_r;
	reg [7:0] fb_level_r;
	wire [24:0] period;
	wire [10:0] pulse_total;
	wire tick;
	wire tick_on;
	reg [6:0] pulse_in_beat_r;
	reg [31:0] out_cnt_r, lamp_cnt_r;
	reg beat_r;

	// Doubled range doubles the loop, so tempo follows delay settings
	assign period = long_range_r ? {loop_len_r, 1'b0} : {1'b0, loop_len_r};
	assign pulse_total = ppb_value(ppb_idx_r) * bpl_value(bpl_idx_r);

	loop_pulse_gen u_gen (.CLK(CLK), .RESET_N(RESET_N), .run(clock_on_r),
		.period(period), .pulse_count(pulse_total), .tick(tick));

	assign tick_on = tick & clock_on_r;

	always @(posedge CLK) begin
		if (!RESET_N) begin
			pulse_in_beat_r <= 7'h00;
			beat_r <= 1'b0;
			out_cnt_r <= 32'h00000000;
			lamp_cnt_r <= 32'h00000000;
			CLOCK_OUT <= 1'b0;
			CLK_LAMP <= 1'b0;
		end else begin
			// Stopping lets the pulse and flash in flight run to full length
			beat_r <= tick_on && (pulse_in_beat_r == 7'h00);
			if (!clock_on_r)
				pulse_in_beat_r <= 7'h00;
			if (tick_on) begin
				if (pulse_in_beat_r + 7'h01 >= ppb_value(ppb_idx_r))
					pulse_in_beat_r <= 7'h00;
				else
					pulse_in_beat_r <= pulse_in_beat_r + 7'h01;
				CLOCK_OUT <= 1'b1;
				out_cnt_r <= 32'h00000000;
			end else if (out_cnt_r >= CLK_PULSE_CYC - 1) begin
				CLOCK_OUT <= 1'b0;
			end else begin
				out_cnt_r <= out_cnt_r + 32'h00000001;
			end
			if (tick_on && (pulse_in_beat_r == 7'h00)) begin
				CLK_LAMP <= 1'b1;
				lamp_cnt_r <= 32'h00000000;
			end else if (lamp_cnt_r >= LAMP_CYC - 1) begin
				CLK_LAMP <= 1'b0;
			end else begin
				lamp_cnt_r <= lamp_cnt_r + 32'h00000001;
			end
		end
	end

	// ----------------------------------------
	// Infinite repeat
	// ----------------------------------------
	reg repeat_r, rpt_pend_r;
	wire rpt_req;
	wire rpt_tog;

	assign rpt_req = rise_rpt | rise_fsw;
	assign rpt_tog = rpt_pend_r ^ rpt_req;

	always @(posedge CLK) begin
		if (!RESET_N) begin
			repeat_r <= 1'b0;
			rpt_pend_r <= 1'b0;
		end else if (!clock_on_r) begin
			repeat_r <= repeat_r ^ rpt_req;
			rpt_pend_r <= 1'b0;
		end else if (beat_r) begin
			repeat_r <= repeat_r ^ rpt_tog;
			rpt_pend_r <= 1'b0;
		end else begin
			rpt_pend_r <= rpt_tog;
		end
	end

	// ----------------------------------------
	// Registered panel and memory outputs
	// ----------------------------------------
	always @(posedge CLK) begin
		if (!RESET_N) begin
			DISP_MODE <= `DISP_DELAY;
			DISP_PPB <= 7'h01;
			DISP_BPL <= 5'h01;
			LONG_RANGE <= 1'b0;
			HOLD_ACTIVE <= 1'b0;
			MEM_WRITE_EN <= 1'b1;
			FEEDBACK_GAIN <= `FB_RESET;
		end else begin
			DISP_MODE <= (state_r == S_CLOFF) ? `DISP_CLOFF :
				(state_r == S_PROG) ? `DISP_PROG : `DISP_DELAY;
			DISP_PPB <= ppb_value(ppb_idx_r);
			DISP_BPL <= bpl_value(bpl_idx_r);
			LONG_RANGE <= long_range_r;
			HOLD_ACTIVE <= repeat_r;
			// Frozen memory replays untouched; writes resume on release
			MEM_WRITE_EN <= ~repeat_r;
			FEEDBACK_GAIN <= repeat_r ? `FB_FULL : fb_level_r;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	reg aw_held_r, w_held_r;
	reg [3:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	always @(posedge CLK) begin
		if (!RESET_N) begin
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= `RESP_OKAY;
			loop_len_r <= `LOOP_LEN_RESET;
			fb_level_r <= `FB_RESET;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_held_r <= 1'b1;
				w_data_r <= WDATA;
				w_strb_r <= WSTRB;
				WREADY <= 1'b0;
			end
			if (aw_held_r && w_held_r && !BVALID) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= `RESP_OKAY;
				case (aw_addr_r)
					`REG_CTRL: begin
						if (w_strb_r[0])
							fb_level_r <= w_data_r[`CTRL_FB_MSB:`CTRL_FB_LSB];
					end
					`REG_LOOP_LEN: begin
						if (w_strb_r[0])
							loop_len_r[7:0] <= w_data_r[7:0];
						if (w_strb_r[1])
							loop_len_r[15:8] <= w_data_r[15:8];
						if (w_strb_r[2])
							loop_len_r[23:16] <= w_data_r[23:16];
					end
					`REG_STATUS, `REG_PROG: BRESP <= `RESP_OKAY;
					default: BRESP <= `RESP_SLVERR;
				endcase
			end
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RRESP <= `RESP_OKAY;
			case (ARADDR)
				`REG_CTRL: RDATA <= {24'h000000, fb_level_r};
				`REG_LOOP_LEN: RDATA <= {8'h00, loop_len_r};
				`REG_STATUS: RDATA <= {26'h0000000, state_r, repeat_r, clock_on_r,
					long_range_r};
				`REG_PROG: RDATA <= {13'h0000, bpl_value(bpl_idx_r), 7'h00,
					ppb_value(ppb_idx_r)};
				default: begin
					RDATA <= 32'h00000000;
					RRESP <= `RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end
endmodule

// File: verilog/loop_pulse_gen.v
// Purpose: spread pulse_count pulses evenly across one loop period
// Assumes: period in system cycles, count never zero
// Notes: fractional accumulator keeps long-term rate exact
`timescale 1ns/10ps
module loop_pulse_gen (
	// Clock and reset
	input wire CLK,
	input wire RESET_N,
	// Control
	input wire run,
	input wire [24:0] period,
	input wire [10:0] pulse_count,
	// Output
	output reg tick
);
	reg [25:0] acc_r;
	wire [25:0] acc_sum;
	wire [25:0] acc_left;

	assign acc_sum = acc_r + {15'h0000, pulse_count};
	assign acc_left = acc_sum - {1'b0, period};

	always @(posedge CLK) begin
		if (!RESET_N || !run) begin
			acc_r <= 26'h0000000;
			tick <= 1'b0;
		end else if (acc_sum >= {1'b0, period}) begin
			// Period rescales tempo live, no restart needed
			// A sharp cut in period leaves a backlog; drop it, never a burst
			acc_r <= (acc_left >= {1'b0, period}) ? 26'h0000000 : acc_left;
			tick <= 1'b1;
		end else begin
			acc_r <= acc_sum;
			tick <= 1'b0;
		end
	end
endmodule
